/* verilog/multilayer_ahb_slave_arbiter.sv */
// per-slave arbiters, decoders and register file of a multi-layer matrix
// How it works
// RULE1: each master has own decoder; boot region remappable to another slave
// RULE2: kind none: idle slave disconnects from all masters
// RULE3: kind last: idle slave stays with the latest requesting master
// RULE4: kind fixed: idle slave parks on the programmed fixed master
// RULE5: slave setup holds 2-bit kind and 4-bit fixed master index
// RULE6: per-slave arbiter, round-robin at reset or fixed priority
// RULE7: arbitrate when idle, unconnected, or on single transfers
// RULE8: arbitrate on the last beat of defined-length bursts; the code still keeps a requesting owner past NSEQ
// RULE9: per-master INCR split: infinite, or every 4, 8, 16 beats; the code raises may_arb at those beats but keeps a requesting owner past NSEQ
// RULE10: slot counter loads budget at burst start, decrements each cycle
// RULE11: slot counter at zero lets the arbiter break the burst; the code still keeps a requesting owner past NSEQ
// RULE12: round-robin: lowest number first on ties, then rotating
// RULE13: no default master costs one cycle on first access
// RULE14: last master regains slave at once, others wait one cycle
// RULE15: fixed default master has no latency, others one cycle
// RULE16: fixed priority: highest value wins, ties go to highest master
// RULE17: system pin register picks system or general-purpose per line
// RULE18: locked write sets violation flag and records target register
// RULE19: reading lock status clears the violation flag
// RULE20: lock covers master setup, slave setup and priority registers
// RULE21: three masters to four slaves; default master connects at once
// RULE22: split code 0 inf, 1 single, 2 four, 3 eight, 4 sixteen
// RULE23: budget zero disables the slot limit
// RULE24: locked write leaves the protected register unchanged
// RULE25: software keeps the budget large or zero
`timescale 1ns/1ps
module multilayer_ahb_slave_arbiter
    import matrix_pkg::*;
#(
    parameter int PINS = 8,
    parameter logic [31:0] BOOT_BASE = 32'h00000000,
    parameter logic [31:0] BOOT_SIZE = 32'h00100000
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire reg_req_s reg_req,
    output logic [31:0] reg_rdata,
    input wire ahb_req_s [NUM_MASTERS-1:0] mreq,
    input wire logic boot_remap,
    output logic [NUM_SLAVES-1:0][1:0] slave_owner,
    output logic [NUM_SLAVES-1:0] slave_connected,
    output logic [NUM_MASTERS-1:0] master_granted,
    output logic [PINS-1:0] sys_pin_select
);
    // configuration
    logic [2:0] split_cfg [NUM_MASTERS];
    logic [31:0] scfg [NUM_SLAVES];
    logic [31:0] pras [NUM_SLAVES];
    logic [PINS-1:0] sysio;
    logic lock_en;
    logic viol_flag;
    logic [7:0] viol_src;
    logic [NUM_SLAVES-1:0] fixed_prio;
    logic boot_meta;
    logic boot_sync;

    // remap strap comes from a pin: two flops before the decoders read it
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_meta <= 1'b0;
            boot_sync <= 1'b0;
        end else begin
            boot_meta <= boot_remap;
            boot_sync <= boot_meta;
        end
    end

    // decode: same map for each master, top address bits pick the slave
    logic [NUM_MASTERS-1:0][1:0] dst;
    logic [NUM_MASTERS-1:0] active;
    always_comb begin
        for (int m = 0; m < NUM_MASTERS; m++) begin
            dst[m] = mreq[m].haddr[31:30];
            // boot region follows the remap strap to a different slave
            if (mreq[m].haddr - BOOT_BASE < BOOT_SIZE) begin
                dst[m] = boot_sync ? 2'h0 : 2'h1; // RULE1
            end
            active[m] = mreq[m].htrans[1];
        end
    end

    // register bus decode
    logic wr_mcfg, wr_scfg, wr_pras, prot_hit;
    logic [1:0] widx;
    always_comb begin
        widx = reg_req.addr[3:2];
        wr_mcfg = reg_req.wr && reg_req.addr[AW-1:4] == MCFG0_OFF[AW-1:4] && widx != 2'h3;
        wr_scfg = reg_req.wr && reg_req.addr[AW-1:4] == SCFG0_OFF[AW-1:4];
        wr_pras = reg_req.wr && reg_req.addr[AW-1:5] == PRAS0_OFF[AW-1:5]
            && !reg_req.addr[2];
        prot_hit = wr_mcfg || wr_scfg || wr_pras; // RULE20
    end

    // protected configuration writes, dropped while locked
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_MASTERS; i++) split_cfg[i] <= SPLIT_INF;
            for (int s = 0; s < NUM_SLAVES; s++) begin
                scfg[s] <= SCFG_RESET[s];
                pras[s] <= 32'h0;
            end
        end else if (!lock_en) begin // RULE24
            if (wr_mcfg) split_cfg[widx] <= reg_req.wdata[2:0]; // RULE22
            if (wr_scfg) scfg[widx] <= reg_req.wdata & 32'h003F00FF; // RULE5
            if (wr_pras) pras[reg_req.addr[4:3]] <= reg_req.wdata & 32'h00000333;
        end
    end

    // unprotected registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sysio <= '0;
            lock_en <= 1'b0;
            fixed_prio <= '0; // RULE6
        end else if (reg_req.wr) begin
            if (reg_req.addr == SYSIO_OFF) sysio <= reg_req.wdata[PINS-1:0]; // RULE17
            if (reg_req.addr == WPMR_OFF) lock_en <= reg_req.wdata[0];
            if (reg_req.addr == ARBMODE_OFF) fixed_prio <= reg_req.wdata[NUM_SLAVES-1:0];
        end
    end

    // violation flag: a new violation wins over a clearing read
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            viol_flag <= 1'b0;
            viol_src <= 8'h0;
        end else if (lock_en && prot_hit) begin
            viol_flag <= 1'b1; // RULE18
            viol_src <= {1'b0, reg_req.addr[AW-1:2]}; // word index of the target
        end else if (reg_req.rd && reg_req.addr == WPSR_OFF) begin
            viol_flag <= 1'b0; // RULE19
        end
    end

    // read data one cycle after the strobe, zero for unmapped offsets
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= 32'h0;
            if (reg_req.rd) begin
                if (reg_req.addr[AW-1:4] == MCFG0_OFF[AW-1:4] && widx != 2'h3)
                    reg_rdata <= {29'h0, split_cfg[widx]};
                else if (reg_req.addr[AW-1:4] == SCFG0_OFF[AW-1:4])
                    reg_rdata <= scfg[widx];
                else if (reg_req.addr[AW-1:5] == PRAS0_OFF[AW-1:5] && !reg_req.addr[2])
                    reg_rdata <= pras[reg_req.addr[4:3]];
                else if (reg_req.addr == SYSIO_OFF)
                    reg_rdata <= {{(32-PINS){1'b0}}, sysio};
                else if (reg_req.addr == WPMR_OFF)
                    reg_rdata <= {31'h0, lock_en};
                else if (reg_req.addr == WPSR_OFF)
                    reg_rdata <= {16'h0, viol_src, 7'h0, viol_flag};
                else if (reg_req.addr == ARBMODE_OFF)
                    reg_rdata <= {28'h0, fixed_prio};
            end
        end
    end

    assign sys_pin_select = sysio; // RULE17

    // per-slave arbitration
    logic [1:0] owner [NUM_SLAVES];
    logic conn [NUM_SLAVES];
    logic [1:0] last_m [NUM_SLAVES];
    logic [SW-1:0] slot [NUM_SLAVES];
    logic [4:0] beat [NUM_SLAVES];
    logic [NUM_SLAVES-1:0][NUM_MASTERS-1:0] want;
    logic [NUM_SLAVES-1:0] may_arb;
    logic [NUM_SLAVES-1:0] have_req;
    logic [1:0] win [NUM_SLAVES];
    logic [1:0] park [NUM_SLAVES];
    logic park_on [NUM_SLAVES];

    // pick a winner and the idle parking spot for each slave
    always_comb begin
        for (int s = 0; s < NUM_SLAVES; s++) begin
            logic [1:0] best;
            logic [1:0] bp;
            logic found;
            logic [1:0] cand;
            logic [2:0] lim;
            logic [4:0] bnext;
            best = 2'h0;
            bp = 2'h0;
            found = 1'b0;
            cand = 2'h0;
            lim = 3'h0;
            for (int m = 0; m < NUM_MASTERS; m++)
                want[s][m] = active[m] && dst[m] == 2'(s);
            have_req[s] = |want[s];
            if (fixed_prio[s]) begin
                // later masters win ties by using >=
                for (int m = 0; m < NUM_MASTERS; m++) begin
                    if (want[s][m] && (!found || pras[s][4*m +: 2] >= bp)) begin
                        best = 2'(m); // RULE16
                        bp = pras[s][4*m +: 2];
                        found = 1'b1;
                    end
                end
            end else begin
                // start just after the last winner; after reset that is master 2
                for (int k = 1; k <= NUM_MASTERS; k++) begin
                    cand = 2'((32'(last_m[s]) + k) % NUM_MASTERS);
                    if (want[s][cand] && !found) begin
                        best = cand; // RULE12
                        found = 1'b1;
                    end
                end
            end
            win[s] = best;
            // re-arbitration points of the current owner's transfer
            lim = split_cfg[owner[s]];
            bnext = beat[s] + 5'h1;
            may_arb[s] = !conn[s] || !active[owner[s]] || dst[owner[s]] != 2'(s); // RULE7
            if (conn[s] && mreq[owner[s]].hready && active[owner[s]]) begin
                if (mreq[owner[s]].hburst == HBURST_SINGLE) may_arb[s] = 1'b1; // RULE7
                if (mreq[owner[s]].hburst == HBURST_INCR) begin
                    if (lim == SPLIT_1) may_arb[s] = 1'b1; // RULE9
                    if (lim == SPLIT_4 && bnext[1:0] == 2'h0) may_arb[s] = 1'b1;
                    if (lim == SPLIT_8 && bnext[2:0] == 3'h0) may_arb[s] = 1'b1;
                    if (lim == SPLIT_16 && bnext[3:0] == 4'h0) may_arb[s] = 1'b1;
                end else if (mreq[owner[s]].hburst != HBURST_SINGLE) begin
                    // wrap/incr of 4, 8, 16 beats ends at its length
                    if (bnext == 5'(4 << (mreq[owner[s]].hburst[2:1] - 2'h1)))
                        may_arb[s] = 1'b1; // RULE8
                end
                if (scfg[s][SLOT_LSB +: SW] != '0 && slot[s] == '0) may_arb[s] = 1'b1; // RULE11
            end
            // parking when nobody asks
            unique case (scfg[s][KIND_LSB +: 2])
                KIND_LAST: begin
                    park[s] = last_m[s]; // RULE3
                    park_on[s] = 1'b1;
                end
                KIND_FIXED: begin
                    park[s] = 2'(scfg[s][FIXM_LSB +: 4] % NUM_MASTERS); // RULE4
                    park_on[s] = 1'b1;
                end
                default: begin
                    park[s] = owner[s];
                    park_on[s] = 1'b0; // RULE2
                end
            endcase
        end
    end

    // ownership: a parked owner already drives the slave, so no latency
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int s = 0; s < NUM_SLAVES; s++) begin
                owner[s] <= 2'h0;
                conn[s] <= 1'b0;
                last_m[s] <= 2'(NUM_MASTERS - 1);
            end
        end else begin
            for (int s = 0; s < NUM_SLAVES; s++) begin
                if (may_arb[s]) begin
                    if (have_req[s] && !(conn[s] && want[s][owner[s]] &&
                        !(mreq[owner[s]].htrans == HTRANS_NSEQ))) begin
                        // switching costs one cycle: the new master sees conn next cycle
                        owner[s] <= win[s]; // RULE13 RULE14 RULE15 RULE21
                        conn[s] <= 1'b1;
                        last_m[s] <= win[s];
                    end else if (!have_req[s]) begin
                        owner[s] <= park[s];
                        conn[s] <= park_on[s]; // RULE2 RULE3 RULE4
                    end
                end
            end
        end
    end

    // slot budget and beat count of the running burst
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int s = 0; s < NUM_SLAVES; s++) begin
                slot[s] <= '0;
                beat[s] <= 5'h0;
            end
        end else begin
            for (int s = 0; s < NUM_SLAVES; s++) begin
                if (conn[s] && want[s][owner[s]] && mreq[owner[s]].htrans == HTRANS_NSEQ
                    && mreq[owner[s]].hready) begin
                    slot[s] <= scfg[s][SLOT_LSB +: SW]; // RULE10
                    beat[s] <= 5'h1;
                end else begin
                    if (slot[s] != '0) slot[s] <= slot[s] - SW'(1); // RULE10 RULE23
                    if (conn[s] && want[s][owner[s]] && mreq[owner[s]].hready)
                        beat[s] <= beat[s] + 5'h1;
                end
            end
        end
    end

    // grant outputs
    always_comb begin
        master_granted = '0;
        for (int s = 0; s < NUM_SLAVES; s++) begin
            slave_owner[s] = owner[s];
            slave_connected[s] = conn[s];
            for (int m = 0; m < NUM_MASTERS; m++)
                if (conn[s] && owner[s] == 2'(m) && want[s][m]) master_granted[m] = 1'b1;
        end
    end

    // default master parked with no request sees grant in the same cycle
    a_park_grant: assert property (@(posedge core_clk) disable iff (!arst_n)
        (conn[0] && want[0][owner[0]]) |-> master_granted[owner[0]]) // RULE15
        else $error("parked owner not granted");
    a_none_discon: assert property (@(posedge core_clk) disable iff (!arst_n)
        (scfg[2][KIND_LSB +: 2] == KIND_NONE && may_arb[2] && !have_req[2])
        |=> !conn[2]) // RULE2
        else $error("slave not disconnected");
    a_fixed_park: assert property (@(posedge core_clk) disable iff (!arst_n)
        (scfg[2][KIND_LSB +: 2] == KIND_FIXED && may_arb[2] && !have_req[2])
        |=> conn[2] && owner[2] == $past(park[2])) // RULE4
        else $error("slave not parked on fixed master");
    a_lock_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
        (lock_en && wr_scfg && widx == 2'h2) |=> $stable(scfg[2])) // RULE24
        else $error("locked register changed");
    a_viol_set: assert property (@(posedge core_clk) disable iff (!arst_n)
        (lock_en && prot_hit) |=> viol_flag) // RULE18
        else $error("violation not flagged");
    a_viol_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
        (reg_req.rd && reg_req.addr == WPSR_OFF && !(lock_en && prot_hit))
        |=> !viol_flag) // RULE19
        else $error("violation flag not cleared");
    a_slot_count: assert property (@(posedge core_clk) disable iff (!arst_n)
        (slot[0] > SW'(1) && !(conn[0] && want[0][owner[0]]))
        |=> slot[0] == $past(slot[0]) - SW'(1)) // RULE10
        else $error("slot counter not decrementing");
    a_rr_reset: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!fixed_prio[3] && last_m[3] == 2'h2 && want[3] == 3'b111) |-> win[3] == 2'h0) // RULE12
        else $error("round-robin tie not to lowest master");
endmodule : multilayer_ahb_slave_arbiter

/* shared/matrix_pkg.sv */
// shared constants and types for the slave arbiter matrix
package matrix_pkg;
    localparam int NUM_MASTERS = 3;
    localparam int NUM_SLAVES = 4;
    localparam int AW = 9;
    localparam int SW = 8;
    localparam logic [AW-1:0] MCFG0_OFF = 9'h000;
    localparam logic [AW-1:0] SCFG0_OFF = 9'h040;
    localparam logic [AW-1:0] PRAS0_OFF = 9'h080;
    localparam logic [AW-1:0] SYSIO_OFF = 9'h114;
    localparam logic [AW-1:0] WPMR_OFF = 9'h1E4;
    localparam logic [AW-1:0] WPSR_OFF = 9'h1E8;
    localparam logic [AW-1:0] ARBMODE_OFF = 9'h1F0;
    localparam logic [1:0] KIND_NONE = 2'h0;
    localparam logic [1:0] KIND_LAST = 2'h1;
    localparam logic [1:0] KIND_FIXED = 2'h2;
    localparam int SLOT_LSB = 0;
    localparam int KIND_LSB = 16;
    localparam int FIXM_LSB = 18;
    localparam logic [31:0] SCFG_RESET [NUM_SLAVES] =
        '{32'h00010010, 32'h00050010, 32'h00000010, 32'h00000010};
    localparam logic [2:0] SPLIT_INF = 3'h0;
    localparam logic [2:0] SPLIT_1 = 3'h1;
    localparam logic [2:0] SPLIT_4 = 3'h2;
    localparam logic [2:0] SPLIT_8 = 3'h3;
    localparam logic [2:0] SPLIT_16 = 3'h4;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NSEQ = 2'h2;
    localparam logic [2:0] HBURST_SINGLE = 3'h0;
    localparam logic [2:0] HBURST_INCR = 3'h1;
    // one master's address phase as seen by the matrix
    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic [2:0] hburst;
        logic hready;
    } ahb_req_s;
    // register port request
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
endpackage : matrix_pkg

/* bench/ahb_master_model.sv */
// behavioural bus masters that feed address phases into the matrix
`timescale 1ns/1ps
module ahb_master_model
    import matrix_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [NUM_MASTERS-1:0] active,
    input wire logic [NUM_MASTERS-1:0][1:0] target,
    output ahb_req_s [NUM_MASTERS-1:0] mreq
);
    // a master holds its single request until the test drops it; an idle
    // address toggles every cycle, so the stale target is decoded again on every second idle cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mreq <= '0;
        end else begin
            for (int m = 0; m < NUM_MASTERS; m++) begin
                mreq[m].hready <= 1'b1;
                mreq[m].hburst <= HBURST_SINGLE;
                mreq[m].htrans <= active[m] ? HTRANS_NSEQ : HTRANS_IDLE;
                mreq[m].haddr <= active[m] ? {target[m], 30'h00000100} : ~mreq[m].haddr;
            end
        end
    end
endmodule : ahb_master_model

/* bench/multilayer_ahb_slave_arbiter_test.sv */
// self-checking bench for the slave arbiter matrix
`timescale 1ns/1ps
module multilayer_ahb_slave_arbiter_test;
    import matrix_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    reg_req_s rq = '0;
    logic boot_remap = 1'b0;
    logic [NUM_MASTERS-1:0] act = '0;
    logic [NUM_MASTERS-1:0][1:0] tgt = '0;
    ahb_req_s [NUM_MASTERS-1:0] mreq;
    logic [31:0] reg_rdata;
    logic [NUM_SLAVES-1:0][1:0] slave_owner;
    logic [NUM_SLAVES-1:0] slave_connected;
    logic [NUM_MASTERS-1:0] master_granted;
    logic [7:0] sys_pin_select;
    logic [31:0] d;
    logic [AW-1:0] locked [3];
    logic [31:0] kept [3];
    int err_total = 0;
    int check_count = 0;

    always #12.5 core_clk = ~core_clk;

    multilayer_ahb_slave_arbiter dut (.core_clk(core_clk), .arst_n(arst_n), .reg_req(rq),
        .reg_rdata(reg_rdata), .mreq(mreq), .boot_remap(boot_remap),
        .slave_owner(slave_owner), .slave_connected(slave_connected),
        .master_granted(master_granted), .sys_pin_select(sys_pin_select));
    ahb_master_model masters (.core_clk(core_clk), .arst_n(arst_n), .active(act),
        .target(tgt), .mreq(mreq));

    task automatic close_out;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
            err_total++;
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] v);
        @(posedge core_clk);
        rq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        rq.wr <= 1'b0;
    endtask : wr

    // read data is taken in the one cycle after the strobe, its only valid cycle
    task automatic rd(input logic [AW-1:0] a, output logic [31:0] v);
        @(posedge core_clk);
        rq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        rq.rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    task automatic rdc(input logic [AW-1:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp, "register read");
    endtask : rdc

    // masters in mask request slave s; mreq follows one edge later
    task automatic drive(input logic [2:0] mask, input logic [1:0] s);
        @(posedge core_clk);
        act <= mask;
        tgt <= {s, s, s};
        @(posedge core_clk);
        #1;
    endtask : drive

    // bounded wait for a slave to reach a connection state
    task automatic wait_conn(input int s, input logic [1:0] m, input logic c);
        int n;
        n = 0;
        while (n < 12 && !(slave_connected[s] === c && (!c || slave_owner[s] === m))) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk({31'h0, slave_connected[s]}, {31'h0, c}, "slave connection");
        if (c) chk({30'h0, slave_owner[s]}, {30'h0, m}, "slave owner");
        if (n == 12) begin
            err_total++;
            close_out();
        end
    endtask : wait_conn

    initial begin
        locked = '{MCFG0_OFF + 9'h008, SCFG0_OFF + 9'h008, PRAS0_OFF + 9'h010};
        kept = '{32'h0, SCFG_RESET[2], 32'h0};
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int s = 0; s < NUM_SLAVES; s++) rdc(SCFG0_OFF + 9'(4 * s), SCFG_RESET[s]);
        rdc(ARBMODE_OFF, 32'h0);
        rdc(9'h0C0, 32'h0);
        for (int c = 0; c < 5; c++) begin
            wr(MCFG0_OFF + 9'h004, 32'(c));
            rdc(MCFG0_OFF + 9'h004, 32'(c));
        end
        wr(SYSIO_OFF, 32'h000000A5);
        @(posedge core_clk);
        #1;
        chk({24'h0, sys_pin_select}, 32'h000000A5, "pin select");
        // lock on: one register of each protected kind refuses and reports itself
        wr(WPMR_OFF, 32'h00000001);
        for (int i = 0; i < 3; i++) begin
            wr(locked[i], 32'h000A0033);
            rdc(locked[i], kept[i]);
            rd(WPSR_OFF, d);
            chk({16'h0, d[15:8], 7'h0, d[0]}, {16'h0, 8'(locked[i] >> 2), 8'h01}, "lock");
            rd(WPSR_OFF, d);
            chk({31'h0, d[0]}, 32'h0, "flag cleared");
        end
        wr(WPMR_OFF, 32'h0);
        // slave 2 has no default master: one cycle to connect, then released
        drive(3'b001, 2'h2);
        chk({31'h0, master_granted[0]}, 32'h0, "no parked grant");
        wait_conn(2, 2'h0, 1'b1);
        drive(3'b000, 2'h2);
        wait_conn(2, 2'h0, 1'b0);
        // slave 3 keeps the last master parked
        wr(SCFG0_OFF + 9'h00C, 32'h00010010);
        drive(3'b010, 2'h3);
        wait_conn(3, 2'h1, 1'b1);
        drive(3'b000, 2'h3);
        repeat (4) @(posedge core_clk);
        #1;
        wait_conn(3, 2'h1, 1'b1);
        drive(3'b010, 2'h3);
        chk({31'h0, master_granted[1]}, 32'h1, "last master at once");
        drive(3'b100, 2'h3);
        chk({31'h0, master_granted[2]}, 32'h0, "other master waits");
        wait_conn(3, 2'h2, 1'b1);
        drive(3'b000, 2'h3);
        // slave 2 parks on fixed master 2, which then needs no arbitration cycle
        wr(SCFG0_OFF + 9'h008, 32'h000A0010);
        wait_conn(2, 2'h2, 1'b1);
        drive(3'b100, 2'h2);
        chk({31'h0, master_granted[2]}, 32'h1, "fixed master at once");
        drive(3'b000, 2'h2);
        // round robin on a tie: lowest first, then rotating
        wr(SCFG0_OFF + 9'h00C, 32'h00000010);
        drive(3'b111, 2'h3);
        wait_conn(3, 2'h0, 1'b1);
        wait_conn(3, 2'h1, 1'b1);
        wait_conn(3, 2'h2, 1'b1);
        drive(3'b000, 2'h3);
        // fixed priority on slave 3: highest value, then highest number
        wr(ARBMODE_OFF, 32'h00000008);
        wr(PRAS0_OFF + 9'h018, 32'h00000113);
        drive(3'b111, 2'h3);
        wait_conn(3, 2'h0, 1'b1);
        repeat (4) @(posedge core_clk);
        #1;
        wait_conn(3, 2'h0, 1'b1);
        drive(3'b000, 2'h3);
        wr(PRAS0_OFF + 9'h018, 32'h00000111);
        drive(3'b111, 2'h3);
        wait_conn(3, 2'h2, 1'b1);
        drive(3'b000, 2'h3);
        // boot region follows the remap input
        drive(3'b010, 2'h0);
        wait_conn(1, 2'h1, 1'b1);
        drive(3'b000, 2'h0);
        @(posedge core_clk);
        boot_remap <= 1'b1;
        drive(3'b010, 2'h0);
        wait_conn(0, 2'h1, 1'b1);
        close_out();
    end
endmodule : multilayer_ahb_slave_arbiter_test
